/* periodic_wakeup_timer_tb.sv */
// self-checking bench of the periodic wake-up timer
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module periodic_wakeup_timer_tb;
  reg clk, tb_rst, por, lfo_tick, thermal_restart_en, thermal_out_of_range, reg_wr, reg_rd, rd_d;
  reg [7:0] reg_addr, reg_wdata;
  reg [7:0] exp_q[$];
  reg [5:0] pre [0:2];
  wire [7:0] reg_rdata;
  wire wake_interrupt, periodic_reset_req, core_rst, sys_rst;
  integer fail_count = 0, comparisons = 0, cyc = 0, trise, t0, k;
  assign sys_rst = tb_rst | core_rst;
  pwt_top dut_u (.clk(clk), .sys_rst(sys_rst), .por(por), .lfo_tick(lfo_tick),
    .thermal_restart_en(thermal_restart_en), .thermal_out_of_range(thermal_out_of_range), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_interrupt(wake_interrupt), .periodic_reset_req(periodic_reset_req));
  pwt_core_model core_u (.clk(clk), .periodic_reset_req(periodic_reset_req), .core_rst(core_rst));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task end_sim;
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
  end
  // read data stands one cycle only, so the monitor looks mid-cycle
  always @(negedge clk) begin
    if (rd_d) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
  end
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 0;
  endtask
  task wait_sig(input bit sel, input integer lim);
    integer i;
    i = 0;
    while ((sel ? periodic_reset_req : wake_interrupt) !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
      if (i > lim) begin
        chk("timeout", 16'h0000, 16'h0001);
        end_sim;
      end
    end
  endtask
  task rise_ack(input [5:0] wi);
    wait_sig(0, 2000);
    trise = cyc;
    rd(8'h1F, 8'h00);
    wr(8'h39, {2'b10, wi});
    rd(8'h39, {2'b10, wi});
    wr(8'h39, {2'b01, wi});
    rd(8'h39, {2'b00, wi});
  endtask
  initial begin
    tb_rst = 1;
    por = 1;
    lfo_tick = 0;
    thermal_restart_en = 0;
    thermal_out_of_range = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    k = $urandom(32'hae91b69f);
    pre[0] = 6'h00;
    pre[1] = 6'($urandom % 63);
    pre[2] = 6'h3F;
    repeat (10) @(posedge clk);
    tb_rst <= 0;
    por <= 0;
    lfo_tick <= 1;
    rd(8'h38, 8'h1F);
    rd(8'h39, 8'h3F);
    rd(8'h3A, 8'h3F);
    rd(8'h1F, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h39, 8'h01);
    // rising settings only, so a running count never passes its new end
    for (k = 0; k < 3; k++) begin
      wr(8'h38, {2'b00, pre[k]});
      rise_ack(6'h01);
      t0 = trise;
      rise_ack(6'h01);
      chk("period", 16'd504 + 16'd16 * pre[k], 16'(trise - t0));
    end
    wr(8'h3A, 8'h00);
    rd(8'h3A, 8'h00);
    wr(8'h39, 8'h00);
    rd(8'h39, 8'h01);
    // interval 3: the blocked event counts, the next one interrupts, the third resets
    wr(8'h3A, 8'h03);
    wr(8'h38, 8'h00);
    thermal_restart_en <= 1;
    thermal_out_of_range <= 1;
    wr(8'h39, 8'h02);
    // long enough for the second wake tick, whose event must stay blocked
    repeat (1100) @(posedge clk);
    #1 chk("blocked", 16'h0000, {15'h0000, wake_interrupt});
    rd(8'h1F, 8'h00);
    wr(8'h1F, 8'h80);
    rd(8'h1F, 8'h81);
    wr(8'h1F, 8'h00);
    thermal_restart_en <= 0;
    thermal_out_of_range <= 0;
    rise_ack(6'h02);
    wait_sig(1, 1200);
    chk("suppressed", 16'h0000, {15'h0000, wake_interrupt});
    repeat (5) @(posedge clk);
    rd(8'h38, 8'h00);
    rd(8'h39, 8'h3F);
    rd(8'h3A, 8'hBF);
    wr(8'h3A, 8'h7F);
    rd(8'h3A, 8'h3F);
    wr(8'h1F, 8'h80);
    rd(8'h1F, 8'h80);
    wr(8'h1F, 8'h00);
    wr(8'h39, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h1F, 8'h3F);
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule // periodic_wakeup_timer_tb

/* pwt_checker_sva.sv */
// port assertions of the periodic wake-up timer
`timescale 1ns/1ps
`include "pwt_regs.vh"
// ****************************************
// checker
// ****************************************
module pwt_checker (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  input wire por,
  // tick and thermal state
  input wire lfo_tick,
  input wire thermal_restart_en,
  input wire thermal_out_of_range,
  // register port
  input wire [`PWT_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // events
  input wire wake_interrupt,
  input wire periodic_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ack_wr = reg_wr && reg_addr == 8'h39 && reg_wdata[6];
  wire blocked = thermal_restart_en && thermal_out_of_range;
  a_reset_pulse: assert property (periodic_reset_req |=> !periodic_reset_req)
    else $error("reset request too long");
  a_thermal_block: assert property (blocked && $past(blocked) |-> !$rose(wake_interrupt) && !periodic_reset_req)
    else $error("event while blocked");
  a_wake_hold: assert property (wake_interrupt && !ack_wr |=> wake_interrupt)
    else $error("interrupt dropped without ack");
  a_ack_clears: assert property ($fell(wake_interrupt) |-> $past(ack_wr))
    else $error("interrupt fell without ack");
  a_reset_wins: assert property (periodic_reset_req |-> !$rose(wake_interrupt))
    else $error("interrupt beside reset");
  a_tick_cause: assert property ($rose(wake_interrupt) || periodic_reset_req |-> $past(lfo_tick))
    else $error("event without tick");
  a_flag_mirror: assert property ($past(reg_rd) && $past(reg_addr) == 8'h39 |-> reg_rdata[7] == $past(wake_interrupt))
    else $error("flag read mismatch");
  a_ack_reads0: assert property ($past(reg_rd) && $past(reg_addr) == 8'h39 |-> reg_rdata[6] == 1'b0)
    else $error("ack bit read nonzero");
endmodule // pwt_checker

bind pwt_top pwt_checker chk_u (.clk(clk), .sys_rst(sys_rst), .por(por), .lfo_tick(lfo_tick),
  .thermal_restart_en(thermal_restart_en), .thermal_out_of_range(thermal_out_of_range), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_interrupt(wake_interrupt), .periodic_reset_req(periodic_reset_req));

/* pwt_core_model.sv */
// reset logic of the core, answering the timer's periodic reset request
`timescale 1ns/1ps
// ****************************************
// core reset model
// ****************************************
module pwt_core_model (
  // clock
  input wire clk,
  // request in, core reset out
  input wire periodic_reset_req,
  output wire core_rst
);
  reg [1:0] hold = 2'h0;
  // held a few cycles so the timer sees a full reset, not a one-cycle glitch
  always @(posedge clk) begin
    if (periodic_reset_req) begin
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  assign core_rst = hold != 2'h0;
endmodule // pwt_core_model

/* pwt_regs.vh */
// register offsets, field positions, reset values and timing counts of the periodic wake-up timer
`ifndef PWT_REGS_VH
`define PWT_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define PWT_ADDR_W 8
`define PWT_OFS_STATUS 8'h1F
`define PWT_OFS_PRESCALE 8'h38
`define PWT_OFS_WAKE_CTRL 8'h39
`define PWT_OFS_RESET_CTRL 8'h3A

// ****************************************
// field positions
// ****************************************
`define PWT_FLAG_BIT 7
`define PWT_ACK_BIT 6
`define PWT_PAGE_BIT 7
`define PWT_FIELD_W 6

// ****************************************
// reset and preset values
// ****************************************
`define PWT_PRESCALE_POR 6'h1F
`define PWT_INTERVAL_RST 6'h3F
`define PWT_COUNTER_MAX 6'h3F

// ****************************************
// prescaler timing, in low-frequency ticks
// ****************************************
`define PWT_PRE_BASE 11'h1F8
`define PWT_PRE_STEP_SHIFT 4
`define PWT_PRE_W 11

`endif

/* pwt_top.v */
// periodic wake-up timer: prescaler, wake-up and periodic reset counters, register port
`timescale 1ns/1ps
`include "pwt_regs.vh"

// ****************************************
// How it works
// ****************************************
// How it works
// - prescaler period is 504 plus 16 times setting
// - only power-on reset loads prescaler with 31
// - counters increment, fire at interval, return zero
// - reset counter counts wake-up events, thermally blocked ones included
// - status reads zero right after an event
// - coinciding reset suppresses the wake-up interrupt
// - thermal out-of-range blocks both outputs while thermal restart is enabled
// - counters keep running and readable while blocked
// - wake-up interrupt ignores global interrupt mask
// - wake flag sets on interrupt, reset clears
// - ack bit clears flag, reads zero
// - wake interval gives 1 to 63 ticks
// - changed wake interval restarts timeout
// - zero wake interval disables, divider forced maximum
// - never both intervals zero; zero disables reset
// - every reset presets wake interval to 63
// - reset flag sets, ack or power-on clears
// - reset interval preset 63, 1 to 63
// - page bit selects counter shown in status

module pwt_top (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  input wire por,
  // low-frequency tick, one cycle per millisecond
  input wire lfo_tick,
  // thermal restart state
  input wire thermal_restart_en,
  input wire thermal_out_of_range,
  // register port
  input wire [`PWT_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // events to the core
  output reg wake_interrupt,
  output reg periodic_reset_req
);

  // ****************************************
  // state
  // ****************************************
  reg [`PWT_FIELD_W-1:0] prescale_setting;
  reg [`PWT_FIELD_W-1:0] wake_interval;
  reg [`PWT_FIELD_W-1:0] reset_interval;
  reg [`PWT_FIELD_W-1:0] wake_cnt;
  reg [`PWT_FIELD_W-1:0] reset_cnt;
  reg [`PWT_PRE_W-1:0] pre_cnt;
  reg wake_flag;
  reg periodic_reset_flag;
  reg page_sel;

  // ****************************************
  // write decode
  // ****************************************
  wire wr_prescale = reg_wr && (reg_addr == `PWT_OFS_PRESCALE);
  wire wr_wake = reg_wr && (reg_addr == `PWT_OFS_WAKE_CTRL);
  wire wr_reset = reg_wr && (reg_addr == `PWT_OFS_RESET_CTRL);
  wire wr_status = reg_wr && (reg_addr == `PWT_OFS_STATUS);
  wire [`PWT_FIELD_W-1:0] wr_field = reg_wdata[`PWT_FIELD_W-1:0];
  wire wr_zero = (wr_field == {`PWT_FIELD_W{1'b0}});

  // a zero write is refused while the other interval is already zero
  wire wake_write_ok = wr_wake && !(wr_zero && (reset_interval == {`PWT_FIELD_W{1'b0}}));
  wire reset_write_ok = wr_reset && !(wr_zero && (wake_interval == {`PWT_FIELD_W{1'b0}}));
  // rewriting the held value must not disturb counting
  wire wake_change = wake_write_ok && (wr_field != wake_interval);
  wire reset_change = reset_write_ok && (wr_field != reset_interval);

  // ****************************************
  // prescaler
  // ****************************************
  wire [`PWT_PRE_W-1:0] pre_period =
    `PWT_PRE_BASE + ({{(`PWT_PRE_W-`PWT_FIELD_W){1'b0}}, prescale_setting} << `PWT_PRE_STEP_SHIFT);
  wire wclk = lfo_tick && (pre_cnt == pre_period - 11'h001);

  always @(posedge clk) begin
    if (sys_rst || wake_change) begin
      pre_cnt <= {`PWT_PRE_W{1'b0}};
    end else if (wclk) begin
      pre_cnt <= {`PWT_PRE_W{1'b0}};
    end else if (lfo_tick) begin
      // a setting lowered below the count wraps once through the full range
      pre_cnt <= pre_cnt + 11'h001;
    end
  end

  // ****************************************
  // wake-up counter
  // ****************************************
  wire wake_enabled = (wake_interval != {`PWT_FIELD_W{1'b0}});
  wire [`PWT_FIELD_W-1:0] wake_cnt_inc = wake_cnt + 6'h01;
  wire wake_event = wclk && wake_enabled && (wake_cnt_inc == wake_interval);

  always @(posedge clk) begin
    if (sys_rst) begin
      wake_cnt <= {`PWT_FIELD_W{1'b0}};
    end else if (wake_write_ok && wr_zero) begin
      wake_cnt <= `PWT_COUNTER_MAX;
    end else if (wake_change) begin
      wake_cnt <= {`PWT_FIELD_W{1'b0}};
    end else if (!wake_enabled) begin
      wake_cnt <= `PWT_COUNTER_MAX;
    end else if (wake_event) begin
      wake_cnt <= {`PWT_FIELD_W{1'b0}};
    end else if (wclk) begin
      // runs on regardless of thermal blocking
      wake_cnt <= wake_cnt_inc;
    end
  end

  // ****************************************
  // periodic reset counter, clocked by wake-up events
  // ****************************************
  wire reset_enabled = (reset_interval != {`PWT_FIELD_W{1'b0}});
  wire [`PWT_FIELD_W-1:0] reset_cnt_inc = reset_cnt + 6'h01;
  wire reset_event = wake_event && reset_enabled && (reset_cnt_inc == reset_interval);

  always @(posedge clk) begin
    if (sys_rst || reset_change || !reset_enabled) begin
      reset_cnt <= {`PWT_FIELD_W{1'b0}};
    end else if (reset_event) begin
      reset_cnt <= {`PWT_FIELD_W{1'b0}};
    end else if (wake_event) begin
      reset_cnt <= reset_cnt_inc;
    end
  end

  // ****************************************
  // event gating
  // ****************************************
  wire thermal_block = thermal_restart_en && thermal_out_of_range;
  wire fire_reset = reset_event && !thermal_block;
  // the reset wins a coincidence, so its wake-up event is dropped
  wire fire_wake = wake_event && !reset_event && !thermal_block;

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst && por) begin
      prescale_setting <= `PWT_PRESCALE_POR;
    end else if (wr_prescale) begin
      prescale_setting <= wr_field;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wake_interval <= `PWT_INTERVAL_RST;
      reset_interval <= `PWT_INTERVAL_RST;
    end else begin
      if (wake_write_ok) begin
        wake_interval <= wr_field;
      end
      if (reset_write_ok) begin
        reset_interval <= wr_field;
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst && por) begin
      page_sel <= 1'b0;
    end else if (wr_status) begin
      page_sel <= reg_wdata[`PWT_PAGE_BIT];
    end
  end

  // ****************************************
  // flags: a new event wins over an ack in the same cycle
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      wake_flag <= 1'b0;
    end else if (fire_wake) begin
      wake_flag <= 1'b1;
    end else if (wr_wake && reg_wdata[`PWT_ACK_BIT]) begin
      wake_flag <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (sys_rst && por) begin
      periodic_reset_flag <= 1'b0;
    end else if (fire_reset) begin
      periodic_reset_flag <= 1'b1;
    end else if (wr_reset && reg_wdata[`PWT_ACK_BIT]) begin
      periodic_reset_flag <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      wake_interrupt <= 1'b0;
      periodic_reset_req <= 1'b0;
    end else begin
      // dedicated line, no global mask sits in its path
      wake_interrupt <= (wake_flag || fire_wake) && !(wr_wake && reg_wdata[`PWT_ACK_BIT] && !fire_wake);
      periodic_reset_req <= fire_reset;
    end
  end

  // ****************************************
  // read port, data one cycle after the strobe
  // ****************************************
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PWT_OFS_PRESCALE: begin
        next_rdata = {2'b00, prescale_setting};
      end
      `PWT_OFS_WAKE_CTRL: begin
        next_rdata = {wake_flag, 1'b0, wake_interval};
      end
      `PWT_OFS_RESET_CTRL: begin
        next_rdata = {periodic_reset_flag, 1'b0, reset_interval};
      end
      `PWT_OFS_STATUS: begin
        next_rdata = {page_sel, 1'b0, page_sel ? reset_cnt : wake_cnt};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // pwt_top
